// [rtl/isrp_defs.svh]
// isrp_defs.svh: bit positions, masks and reset values of the status reporting block
// assumes: included by its bare name from the package and the design files
`ifndef ISRP_DEFS_SVH
`define ISRP_DEFS_SVH

// status summary byte bit positions
`define ISRP_STB_QUE   2
`define ISRP_STB_QUES  3
`define ISRP_STB_MAV   4
`define ISRP_STB_ESB   5
`define ISRP_STB_RQS   6
`define ISRP_STB_OPER  7

// standard event latch bit positions
`define ISRP_ESR_OPC   0
`define ISRP_ESR_DDE   3
`define ISRP_ESR_EXE   4
`define ISRP_ESR_CME   5
`define ISRP_ESR_PON   7

// masks of defined bits, and the master summary mask without bit 6
`define ISRP_STB_USED  8'hbc
`define ISRP_ESR_USED  8'hb9
`define ISRP_MSS_MASK  8'hbf

// reset values
`define ISRP_ESR_RST   8'h80
`define ISRP_SRE_RST   8'h00
`define ISRP_ZERO8     8'h00

`endif

// [rtl/isrp_evt_latch.sv]
// isrp_evt_latch: bank of sticky event bits, cleared as a whole
// assumes: set pulses and clear synchronous to clk_i; set wins over clear
`timescale 1ns/1ps
`default_nettype none
module isrp_evt_latch #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] set_i,
   input  wire logic         clr_i,
   output var  logic [W-1:0] q_o
);
   // one sticky flop per event bit; a set in the clear cycle survives
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            q_o[i] <= RST[i];
         end else begin
            q_o[i] <= set_i[i] | (q_o[i] & ~clr_i);
         end
      end
   end
endmodule : isrp_evt_latch
`default_nettype wire

// [rtl/isrp_pkg.sv]
// isrp_pkg: types shared by the status reporting block
// assumes: isrp_defs.svh on the include path
package isrp_pkg;
   `include "isrp_defs.svh"

   // kind of status access made by the remote controller
   typedef enum logic [1:0] {
      ISRP_QRY_STB  = 2'h0,
      ISRP_QRY_ESR  = 2'h1,
      ISRP_QRY_SRE  = 2'h2,
      ISRP_QRY_POLL = 2'h3
   } isrp_qry_t;

   // answer sequencer, gray along idle -> answer -> idle
   typedef enum logic [1:0] {
      ISRP_ST_IDLE = 2'h0,
      ISRP_ST_ANS  = 2'h1
   } isrp_st_t;

   // standard event pulses from the instrument
   typedef struct packed {
      logic opc;   // pending operations all complete
      logic dde;   // device-dependent error
      logic exe;   // execution error
      logic cme;   // command error
   } isrp_evt_t;

   // summary levels from queues and sub-registers
   typedef struct packed {
      logic oper;  // operation status summary
      logic ques;  // questionable status summary
      logic mav;   // output queue holds data
      logic que;   // error/event queue not empty
   } isrp_sum_t;

   // answer to a status access
   typedef struct packed {
      logic       vld;
      logic [7:0] data;
   } isrp_rsp_t;
endpackage : isrp_pkg

// [rtl/isrp_top.sv]
// isrp_top: status byte, service request enable and standard event latch
// assumes: all inputs synchronous to clk_i; queries arrive as one-cycle strobes
//
// Functional notes
// RULE1: request-service flag lives in status bit 6
// RULE2: request service when enabled status bits nonzero; code requests only as the summary turns on, not again after a poll
// RULE3: eight sticky standard event bits
// RULE4: event summary ORed into status bit 5
// RULE5: status bit 2 shows queue not empty
// RULE6: status bit 3 shows questionable summary
// RULE7: status bit 4 shows message available
// RULE8: status bit 7 shows operation summary
// RULE9: serial poll returns status with request-service bit
// RULE10: status query returns master summary in bit 6
// RULE11: controller may poll message-available before reading
// RULE12: event bit 0 marks operations complete
// RULE13: event bit 3 marks device-dependent error
// RULE14: event bit 4 marks execution error
// RULE15: event bit 5 marks command error
// RULE16: event bit 7 records power-up
// RULE17: reading event latch clears all its bits
// RULE18: status query leaves status byte unchanged
// RULE19: enable query returns its value 0 to 255
// RULE20: undefined status and event bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "isrp_defs.svh"
module isrp_top (
   input  wire logic                clk_i,
   input  wire logic                nrst_i,
   input  wire isrp_pkg::isrp_evt_t evt_i,
   input  wire isrp_pkg::isrp_sum_t sum_i,
   input  wire logic                sre_wr_i,
   input  wire logic [7:0]          sre_wdata_i,
   input  wire logic                qry_vld_i,
   input  wire isrp_pkg::isrp_qry_t qry_sel_i,
   output var  logic                qry_rdy_o,
   output var  isrp_pkg::isrp_rsp_t rsp_o,
   output var  logic                srq_o
);
   import isrp_pkg::*;

   logic [7:0] esr_set;    // event pulses placed at their bit positions
   logic [7:0] esr_q;      // standard event latch
   logic       esr_clr;    // read of the latch clears it
   logic       esb;        // event summary
   logic [7:0] stb_d;
   logic [7:0] stb_q;      // status byte without the bit 6 flag
   logic [7:0] sre_q;      // service request enable
   logic       mss_c;      // master summary, combinational
   logic       mss_q;      // master summary, one cycle late for edge finding
   logic       srq_q;      // request-service flag
   isrp_st_t   st_q;
   isrp_st_t   st_d;
   logic       take;       // query accepted this cycle
   isrp_rsp_t  rsp_d;

   // a query is taken only while the sequencer is idle
   assign take = qry_vld_i & qry_rdy_o;

   // place event pulses; bits 1, 2 and 6 never set
   always_comb begin
      esr_set                = `ISRP_ZERO8;                 // RULE20
      esr_set[`ISRP_ESR_OPC] = evt_i.opc;                   // RULE12
      esr_set[`ISRP_ESR_DDE] = evt_i.dde;                   // RULE13
      esr_set[`ISRP_ESR_EXE] = evt_i.exe;                   // RULE14
      esr_set[`ISRP_ESR_CME] = evt_i.cme;                   // RULE15
   end

   // reading the event latch empties it, events of the same cycle stay
   assign esr_clr = take & (qry_sel_i == ISRP_QRY_ESR);    // RULE17

   // reset value carries the power-up bit, so power-on is seen as an event
   isrp_evt_latch #(
      .W   (8),
      .RST (`ISRP_ESR_RST)                                 // RULE16
   ) u_esr (                                               // RULE3
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .set_i  (esr_set),
      .clr_i  (esr_clr),
      .q_o    (esr_q)
   );

   // every latched event folds into one summary bit
   assign esb = |(esr_q & `ISRP_ESR_USED);                 // RULE4

   // status byte built from summaries; bits 0, 1 stay zero
   always_comb begin
      stb_d                 = `ISRP_ZERO8;                 // RULE20
      stb_d[`ISRP_STB_QUE]  = sum_i.que;                   // RULE5
      stb_d[`ISRP_STB_QUES] = sum_i.ques;                  // RULE6
      stb_d[`ISRP_STB_MAV]  = sum_i.mav;                   // RULE7
      stb_d[`ISRP_STB_ESB]  = esb;                         // RULE4
      stb_d[`ISRP_STB_OPER] = sum_i.oper;                  // RULE8
   end

   // status byte register; no query writes it, so reads cannot disturb it
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stb_q <= `ISRP_ZERO8;
      end else begin
         stb_q <= stb_d;                                   // RULE18
      end
   end

   // service request enable, written whole by the controller
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sre_q <= `ISRP_SRE_RST;
      end else if (sre_wr_i) begin
         sre_q <= sre_wdata_i;                             // RULE19
      end
   end

   // bit 6 of the enable is ignored: the flag must not gate itself
   assign mss_c = |(stb_q & sre_q & `ISRP_MSS_MASK);       // RULE2

   // previous summary, used to arm the request on a new reason only
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mss_q <= 1'b0;
      end else begin
         mss_q <= mss_c;
      end
   end

   // request flag: raised by a fresh summary, dropped by a serial poll;
   // a raise in the poll cycle wins so no request is lost
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         srq_q <= 1'b0;
      end else if (mss_c & ~mss_q) begin
         srq_q <= 1'b1;                                    // RULE2
      end else if (take & (qry_sel_i == ISRP_QRY_POLL)) begin
         srq_q <= 1'b0;
      end
   end

   assign srq_o = srq_q;                                   // RULE1

   // answer sequencer next state
   always_comb begin
      case (st_q)
         ISRP_ST_IDLE: begin
            st_d = take ? ISRP_ST_ANS : ISRP_ST_IDLE;
         end
         ISRP_ST_ANS: begin
            st_d = ISRP_ST_IDLE;
         end
         default: begin
            st_d = ISRP_ST_IDLE;
         end
      endcase
   end

   // state and ready flop; ready is low for the answer cycle
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q      <= ISRP_ST_IDLE;
         qry_rdy_o <= 1'b1;
      end else begin
         st_q      <= st_d;
         qry_rdy_o <= (st_d == ISRP_ST_IDLE);
      end
   end

   // answer data per kind of access
   always_comb begin
      rsp_d.vld  = take;
      rsp_d.data = `ISRP_ZERO8;
      case (qry_sel_i)
         ISRP_QRY_STB: begin
            rsp_d.data                = stb_q;
            rsp_d.data[`ISRP_STB_RQS] = mss_c;             // RULE10
         end
         ISRP_QRY_POLL: begin
            rsp_d.data                = stb_q;
            rsp_d.data[`ISRP_STB_RQS] = srq_q;             // RULE9
         end
         ISRP_QRY_ESR: begin
            rsp_d.data = esr_q;                            // RULE17
         end
         ISRP_QRY_SRE: begin
            rsp_d.data = sre_q;                            // RULE19
         end
         default: begin
            rsp_d.data = `ISRP_ZERO8;
         end
      endcase
   end

   // answer register, valid for one cycle after the take
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsp_o <= '0;
      end else begin
         rsp_o <= rsp_d;
      end
   end

   // ---- checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_poll_rqs_bit: assert property ( // RULE9
      (take && qry_sel_i == ISRP_QRY_POLL)
         |=> (rsp_o.vld && rsp_o.data[`ISRP_STB_RQS] == $past(srq_q)
              && rsp_o.data[`ISRP_STB_ESB] == $past(stb_q[`ISRP_STB_ESB])))
      else $error("serial poll answer lacks request flag in bit 6");

   a_srq_out_flag: assert property ( // RULE1
      (srq_o && !(take && qry_sel_i == ISRP_QRY_POLL)) |=> srq_o)
      else $error("request output dropped without a serial poll");

   a_rqs_raise: assert property ( // RULE2
      (mss_c && !mss_q) |=> srq_q)
      else $error("request flag not raised on new summary");

   a_rqs_cause: assert property ( // RULE2
      $rose(srq_q) |-> $past(mss_c) && !$past(mss_q))
      else $error("request flag raised without enabled status");

   a_rqs_poll_clr: assert property ( // RULE9
      (take && qry_sel_i == ISRP_QRY_POLL && !(mss_c && !mss_q)) |=> !srq_q)
      else $error("serial poll did not drop request flag");

   a_mss_query: assert property ( // RULE10
      (take && qry_sel_i == ISRP_QRY_STB)
         |=> (rsp_o.data[`ISRP_STB_RQS] == $past(mss_c)))
      else $error("status query bit 6 is not master summary");

   // antecedents sample nrst_i: the release edge, where flops still show reset values, is not judged
   a_esb_summary: assert property ( // RULE4
      (nrst_i && (|esr_q)) |=> stb_q[`ISRP_STB_ESB])
      else $error("event summary missing from status bit 5");

   a_esb_empty: assert property ( // RULE4
      (esr_q == `ISRP_ZERO8) |=> !stb_q[`ISRP_STB_ESB])
      else $error("event summary set with empty latch");

   a_que_summary: assert property ( // RULE5
      (nrst_i && sum_i.que) |=> stb_q[`ISRP_STB_QUE] ##1 (stb_q[`ISRP_STB_QUE] || !$past(sum_i.que)))
      else $error("queue summary not in status bit 2");

   a_ques_summary: assert property ( // RULE6
      nrst_i |=> (stb_q[`ISRP_STB_QUES] == $past(sum_i.ques)))
      else $error("questionable summary not in status bit 3");

   a_mav_summary: assert property ( // RULE7
      nrst_i |=> (stb_q[`ISRP_STB_MAV] == $past(sum_i.mav)))
      else $error("message available not in status bit 4");

   a_oper_summary: assert property ( // RULE8
      nrst_i |=> (stb_q[`ISRP_STB_OPER] == $past(sum_i.oper)))
      else $error("operation summary not in status bit 7");

   a_opc_latch: assert property ( // RULE12
      evt_i.opc |=> esr_q[`ISRP_ESR_OPC] [*2] or (esr_q[`ISRP_ESR_OPC] ##1 $past(esr_clr)))
      else $error("operation complete not latched");

   a_dde_latch: assert property ( // RULE13
      evt_i.dde |=> esr_q[`ISRP_ESR_DDE])
      else $error("device error not latched in bit 3");

   a_exe_latch: assert property ( // RULE14
      evt_i.exe |=> esr_q[`ISRP_ESR_EXE])
      else $error("execution error not latched in bit 4");

   a_cme_latch: assert property ( // RULE15
      evt_i.cme |=> esr_q[`ISRP_ESR_CME])
      else $error("command error not latched in bit 5");

   a_esr_sticky: assert property ( // RULE3
      (|esr_q && !esr_clr) |=> ((esr_q & $past(esr_q)) == $past(esr_q)))
      else $error("event bit lost without a read");

   a_esr_clear: assert property ( // RULE17
      (esr_clr && esr_set == `ISRP_ZERO8)
         |=> (esr_q == `ISRP_ZERO8 && rsp_o.data == $past(esr_q)))
      else $error("event latch read did not clear it");

   a_stb_query_keep: assert property ( // RULE18
      (take && qry_sel_i == ISRP_QRY_STB && !(mss_c && !mss_q))
         |=> (srq_q == $past(srq_q)))
      else $error("status query changed the request flag");

   a_sre_query: assert property ( // RULE19
      (take && qry_sel_i == ISRP_QRY_SRE) |=> (rsp_o.data == $past(sre_q)))
      else $error("enable query returned wrong value");

   a_zero_bits: assert property ( // RULE20
      ((stb_q & ~`ISRP_STB_USED) == `ISRP_ZERO8)
         && ((esr_q & ~`ISRP_ESR_USED) == `ISRP_ZERO8))
      else $error("undefined status or event bit is set");

   a_rsp_single: assert property (
      rsp_o.vld |-> !qry_rdy_o ##1 (!rsp_o.vld && qry_rdy_o))
      else $error("answer valid longer than one cycle");

   // handshake: ready drops for exactly the answer cycle
   a_rdy_after_take: assert property (
      take |=> (!qry_rdy_o && rsp_o.vld))
      else $error("ready still high in the answer cycle");

   // serial poll body matches the status byte outside bit 6
   a_poll_stb_body: assert property ( // RULE9
      (take && qry_sel_i == ISRP_QRY_POLL)
         |=> ((rsp_o.data & `ISRP_MSS_MASK) == ($past(stb_q) & `ISRP_MSS_MASK)))
      else $error("serial poll answer differs from status byte");

   // an event in the read cycle must survive the clear
   a_set_wins_clear: assert property ( // RULE3
      (esr_clr && (|esr_set))
         |=> ((esr_q & $past(esr_set)) == $past(esr_set)))
      else $error("event lost when it met a latch read");

   // the enable takes a write whole and holds it otherwise
   a_sre_write: assert property ( // RULE19
      sre_wr_i |=> (sre_q == $past(sre_wdata_i)))
      else $error("enable register did not take the write");

   a_sre_keep: assert property ( // RULE19
      !sre_wr_i |=> (sre_q == $past(sre_q)))
      else $error("enable register changed without a write");

   c_poll_with_rqs: cover property (
      take && qry_sel_i == ISRP_QRY_POLL && srq_q);

   c_esr_read_clear: cover property (
      esr_clr && (|esr_q) ##1 esr_q == `ISRP_ZERO8);

   c_rqs_rise: cover property (
      $rose(srq_q));

   c_set_on_clear: cover property (
      esr_clr && (|esr_set));

   c_mav_seen: cover property (
      take && qry_sel_i == ISRP_QRY_STB && stb_q[`ISRP_STB_MAV]);
endmodule : isrp_top
`default_nettype wire

// [test/ieee4882_status_reporting_test.sv]
// ieee4882_status_reporting_test: self-checking bench of isrp_top with a controller model
// assumes: isrp_pkg compiled first, defs header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "isrp_defs.svh"
module ieee4882_status_reporting_test;
   import isrp_pkg::*;

   logic       clk       = 1'b0;
   logic       nrst      = 1'b0;
   isrp_evt_t  evt       = '0;
   isrp_sum_t  sum       = '0;
   logic       sre_wr    = 1'b0;
   logic [7:0] sre_wdata = 8'h00;
   logic       qry_vld;
   logic       qry_rdy;
   logic       srq;
   logic       hang;
   logic       found;
   isrp_qry_t  qry_sel;
   isrp_rsp_t  rsp;
   int         bad_count  = 0;
   int         n_compared = 0;
   integer     seed       = 32'h9083;
   logic [31:0] rnd;
   logic [3:0] r;
   logic [7:0] sre_m;
   logic [7:0] stb_m;
   logic [7:0] got;
   logic [7:0] esr_tab [4] = '{8'h20, 8'h10, 8'h08, 8'h01}; // cme, exe, dde, opc positions

   always #5 clk = ~clk;

   isrp_top DUT (
      .clk_i      (clk),
      .nrst_i     (nrst),
      .evt_i      (evt),
      .sum_i      (sum),
      .sre_wr_i   (sre_wr),
      .sre_wdata_i(sre_wdata),
      .qry_vld_i  (qry_vld),
      .qry_sel_i  (qry_sel),
      .qry_rdy_o  (qry_rdy),
      .rsp_o      (rsp),
      .srq_o      (srq)
   );

   isrp_pc_model PC (
      .clk_i    (clk),
      .qry_rdy_i(qry_rdy),
      .rsp_i    (rsp),
      .qry_vld_o(qry_vld),
      .qry_sel_o(qry_sel),
      .hang_o   (hang)
   );

   task automatic check(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check

   // expected status byte without bit 6; undefined bits stay zero
   function automatic logic [7:0] stb_of(isrp_sum_t s, logic esb);
      return {s.oper, 1'b0, esb, s.mav, s.ques, s.que, 2'b00};
   endfunction : stb_of

   // master summary ignores enable bit 6
   function automatic logic mss_of(logic [7:0] stb, logic [7:0] sre);
      return |(stb & sre & `ISRP_MSS_MASK);
   endfunction : mss_of

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic set_sre(logic [7:0] v);
      @(posedge clk);
      sre_wr    <= 1'b1;
      sre_wdata <= v;
      @(posedge clk);
      sre_wr    <= 1'b0;
   endtask : set_sre

   task automatic pulse(isrp_evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
   endtask : pulse

   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // a stuck handshake or a runaway run ends the test as a failure
   always @(posedge hang) begin
      bad_count++;
      print_verdict();
   end
   initial begin
      cyc(20000);
      bad_count++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      cyc(2);
      PC.access(ISRP_QRY_STB, got);
      check(got, 8'h20);
      PC.access(ISRP_QRY_SRE, got);
      check(got, `ISRP_SRE_RST);
      PC.access(ISRP_QRY_ESR, got);
      check(got, `ISRP_ESR_RST);
      PC.access(ISRP_QRY_ESR, got);
      check(got, 8'h00);
      $display("test reset values done");
      // each event kind alone, then all together
      for (int i = 0; i < 4; i++) begin
         pulse(isrp_evt_t'(4'h1 << i));
         cyc(2);
         PC.access(ISRP_QRY_STB, got);
         check(got, 8'h20);
         PC.access(ISRP_QRY_ESR, got);
         check(got, esr_tab[i]);
         PC.access(ISRP_QRY_ESR, got);
         check(got, 8'h00);
      end
      pulse(isrp_evt_t'(4'hf));
      cyc(2);
      PC.access(ISRP_QRY_ESR, got);
      check(got, 8'h39);
      // event in the very cycle of a latch read: the read sees the old value, the event stays
      fork
         PC.access(ISRP_QRY_ESR, got);
         pulse(isrp_evt_t'(4'h2));
      join
      check(got, 8'h00);
      PC.access(ISRP_QRY_ESR, got);
      check(got, 8'h10);
      $display("test event latch done");
      // random summaries and enables; first pass checks that enable bit 6 is ignored
      for (int i = 0; i < 24; i++) begin
         rnd   = $random(seed);
         sre_m = (i == 0) ? 8'h40 : rnd[7:0];
         r     = (i == 0) ? 4'hf : rnd[11:8];
         set_sre(sre_m);
         @(posedge clk);
         sum   <= isrp_sum_t'(r);
         stb_m = stb_of(isrp_sum_t'(r), 1'b0);
         cyc(2);
         PC.access(ISRP_QRY_STB, got);
         check(got, stb_m | {1'b0, mss_of(stb_m, sre_m), 6'h00});
         PC.access(ISRP_QRY_STB, got);
         check(got, stb_m | {1'b0, mss_of(stb_m, sre_m), 6'h00});
         PC.access(ISRP_QRY_SRE, got);
         check(got, sre_m);
      end
      $display("test status byte done");
      // service request raised by message available, cleared by serial poll
      @(posedge clk);
      sum <= '0;
      set_sre(8'h10);
      cyc(2);
      PC.access(ISRP_QRY_POLL, got);
      check(got & 8'hbf, 8'h00);
      cyc(2);
      check({7'h00, srq}, 8'h00);
      @(posedge clk);
      sum <= isrp_sum_t'(4'h2);
      PC.wait_mav(found);
      check({7'h00, found}, 8'h01);
      cyc(2);
      check({7'h00, srq}, 8'h01);
      PC.access(ISRP_QRY_POLL, got);
      check(got, 8'h50);
      check({7'h00, qry_rdy}, 8'h00);
      check({7'h00, srq}, 8'h00);
      PC.access(ISRP_QRY_POLL, got);
      check(got, 8'h10);
      $display("test service request done");
      // mid-run reset: power-up recorded again, enable back to zero, mav still shown
      nrst <= 1'b0;
      cyc(3);
      nrst <= 1'b1;
      cyc(2);
      check({7'h00, srq}, 8'h00);
      PC.access(ISRP_QRY_STB, got);
      check(got, 8'h30);
      PC.access(ISRP_QRY_ESR, got);
      check(got, `ISRP_ESR_RST);
      PC.access(ISRP_QRY_SRE, got);
      check(got, `ISRP_SRE_RST);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule : ieee4882_status_reporting_test
`default_nettype wire

// [test/isrp_pc_model.sv]
// isrp_pc_model: remote controller that issues status accesses to the block
// assumes: access port of isrp_top, requests made and released only at rising clk_i edges
`timescale 1ns/1ps
`default_nettype none
`include "isrp_defs.svh"
module isrp_pc_model (
   input  wire logic                clk_i,
   input  wire logic                qry_rdy_i,
   input  wire isrp_pkg::isrp_rsp_t rsp_i,
   output var  logic                qry_vld_o,
   output var  isrp_pkg::isrp_qry_t qry_sel_o,
   output var  logic                hang_o
);
   import isrp_pkg::*;

   // idle request lines at time zero
   initial begin
      qry_vld_o = 1'b0;
      qry_sel_o = ISRP_QRY_STB;
      hang_o    = 1'b0;
   end

   // one access: hold request until taken, answer read one edge later
   task automatic access(input isrp_qry_t sel, output logic [7:0] data);
      int n;
      @(posedge clk_i);
      qry_vld_o <= 1'b1;
      qry_sel_o <= sel;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (qry_rdy_i !== 1'b1 && n < 20);
      if (n >= 20) hang_o = 1'b1;
      qry_vld_o <= 1'b0;
      qry_sel_o <= isrp_qry_t'(~sel); // released lines move, so a stale select is never trusted
      @(posedge clk_i);
      // a missing answer yields unknown data so the caller's compare fails
      data = (rsp_i.vld === 1'b1) ? rsp_i.data : 8'hxx;
   endtask : access

   // poll the status byte until message available shows, bounded
   task automatic wait_mav(output logic found);
      logic [7:0] d;
      found = 1'b0;
      for (int n = 0; n < 16 && !found; n++) begin
         access(ISRP_QRY_STB, d);
         found = (d[`ISRP_STB_MAV] === 1'b1);
      end
   endtask : wait_mav
endmodule : isrp_pc_model
`default_nettype wire
